// *** ims_regs.vh ***
// register offsets, field positions and reset values of the interrupt source gate stage
`ifndef IMS_REGS_VH
`define IMS_REGS_VH

`define IMS_ADDR_W 8
`define IMS_DATA_W 32
`define IMS_SRC_N 14

`define IMS_GATED_VIEW_OFS 8'h2C
`define IMS_GATE_OFS 8'h30
`define IMS_UNGATED_VIEW_OFS 8'h34

`define IMS_BIT_RX_UNDER 0
`define IMS_BIT_RX_OVER 1
`define IMS_BIT_RX_FULL 2
`define IMS_BIT_TX_OVER 3
`define IMS_BIT_TX_EMPTY 4
`define IMS_BIT_RD_REQ 5
`define IMS_BIT_TRANSMIT_ABORTED 6
`define IMS_BIT_XFER_DONE 7
`define IMS_BIT_BUS_ACTIVITY 8
`define IMS_BIT_STOP_CONDITION 9
`define IMS_BIT_START_CONDITION 10
`define IMS_BIT_GENERAL_CALL 11
`define IMS_BIT_REPEATED_START 12
`define IMS_BIT_HOLD_EMPTY 13

`define IMS_GATE_RESET 14'h08FF
`define IMS_GATE_WRITABLE 14'h1FFF

`endif

// *** ims_gate.v ***
// per-source gating of raw event flags and the or of the gated view
`timescale 1ns/10ps
`default_nettype none
`include "ims_regs.vh"

module ims_gate
(
	// raw flags and gate bits
	input wire [`IMS_SRC_N-1:0] i_raw,
	input wire [`IMS_SRC_N-1:0] i_gate,
	// gated view and its combined request
	output wire [`IMS_SRC_N-1:0] o_gated,
	output wire o_any
);

	genvar gi;
	generate
		for (gi = 0; gi < `IMS_SRC_N; gi = gi + 1)
		begin : g_src
			// a zero gate bit hides the source, a one passes it
			assign o_gated[gi] = i_raw[gi] & i_gate[gi];
		end
	endgenerate

	assign o_any = |o_gated;

endmodule
`default_nettype wire

// *** ims_mask_stage.v ***
// interrupt source gate register, gated and ungated event views, request output
//
// What this block does
// - gate bit zero hides its source, one passes it through
// - bit 13 hold-with-empty-queue gate is read-only, resets zero, ignores writes
// - bit 12 repeated-start gate is read-write, resets zero
// - bit 11 general-call gate is read-write, resets one
// - bit 10 start-condition gate is read-write, resets zero
// - bit 9 stop-condition gate is read-write, resets zero
// - bit 8 bus-activity gate is read-write, resets zero
// - bit 7 transfer-finished gate is read-write, resets one
// - bit 6 transmit-aborted gate is read-write, resets one
// - bit 5 read-request gate is read-write, resets one
// - bit 4 transmit-queue-empty gate is read-write, resets one
// - bit 3 transmit-queue-overflow gate is read-write, resets one
// - bit 2 receive-queue-full gate is read-write, resets one
// - bit 1 receive-queue-overflow gate is read-write, resets one
// - bit 0 receive-queue-underflow gate is read-write, resets one
// - each gated view bit is its raw flag anded with its gate bit
// - ungated view shows raw flags regardless of gate settings
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ims_regs.vh"

module ims_mask_stage
(
	// clock and reset
	input wire I_CORE_CLK,
	input wire I_RESET,
	// register port
	input wire [`IMS_ADDR_W-1:0] I_ADDR,
	input wire [`IMS_DATA_W-1:0] I_WDATA,
	input wire I_WRITE,
	input wire I_READ,
	output reg [`IMS_DATA_W-1:0] O_RDATA,
	// raw event flags from the controller core, same clock
	input wire [`IMS_SRC_N-1:0] I_RAW_EVENTS,
	// gated view, gate register copy and request
	output reg [`IMS_SRC_N-1:0] O_GATED_VIEW,
	output reg [`IMS_SRC_N-1:0] O_GATE,
	output reg O_IRQ
);

	localparam [`IMS_SRC_N-1:0] GATE_RESET = `IMS_GATE_RESET;
	localparam [`IMS_SRC_N-1:0] GATE_WRITABLE = `IMS_GATE_WRITABLE;
	localparam [`IMS_DATA_W-`IMS_SRC_N-1:0] UPPER_ZERO = 18'h00000;

	reg [`IMS_SRC_N-1:0] gate_reg;
	reg [`IMS_DATA_W-1:0] rdata_next;
	wire [`IMS_SRC_N-1:0] gated_now;
	wire any_now;
	wire gate_wr;

	assign gate_wr = I_WRITE && (I_ADDR == `IMS_GATE_OFS);

	// each gate bit is its own flop so reset values and write access stay per source
	genvar gi;
	generate
		for (gi = 0; gi < `IMS_SRC_N; gi = gi + 1)
		begin : g_gate
			if (GATE_WRITABLE[gi])
			begin : g_rw
				always @(posedge I_CORE_CLK)
				begin
					if (I_RESET)
						gate_reg[gi] <= GATE_RESET[gi];
					else if (gate_wr)
						gate_reg[gi] <= I_WDATA[gi];
				end
			end
			else
			begin : g_ro
				// held at its reset value so the hold-with-empty-queue source stays hidden
				always @(posedge I_CORE_CLK)
				begin
					gate_reg[gi] <= GATE_RESET[gi];
				end
			end
		end
	endgenerate

	ims_gate u_gate
	(
		.i_raw(I_RAW_EVENTS),
		.i_gate(gate_reg),
		.o_gated(gated_now),
		.o_any(any_now)
	);

	// read mux; upper bits are constant zero and never stored
	always @*
	begin
		rdata_next = {`IMS_DATA_W{1'b0}};
		if (I_READ)
		begin
			case (I_ADDR)
				`IMS_GATE_OFS: rdata_next = {UPPER_ZERO, gate_reg};
				`IMS_GATED_VIEW_OFS: rdata_next = {UPPER_ZERO, gated_now};
				`IMS_UNGATED_VIEW_OFS: rdata_next = {UPPER_ZERO, I_RAW_EVENTS};
				default: rdata_next = {`IMS_DATA_W{1'b0}};
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always @(posedge I_CORE_CLK)
	begin
		if (I_RESET)
		begin
			O_RDATA <= {`IMS_DATA_W{1'b0}};
			O_GATED_VIEW <= {`IMS_SRC_N{1'b0}};
			O_GATE <= GATE_RESET;
			O_IRQ <= 1'b0;
		end
		else
		begin
			O_RDATA <= rdata_next;
			O_GATED_VIEW <= gated_now;
			O_GATE <= gate_reg;
			O_IRQ <= any_now;
		end
	end

endmodule
`default_nettype wire

// *** ims_mask_stage_monitor.sv ***
// assertions on the ports of the mask stage
`timescale 1ns/10ps
`default_nettype none
module ims_chk
(
	// all ports of the stage, watched only
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WRITE,
	input wire logic I_READ,
	input wire logic [31:0] O_RDATA,
	input wire logic [13:0] I_RAW_EVENTS,
	input wire logic [13:0] O_GATED_VIEW,
	input wire logic [13:0] O_GATE,
	input wire logic O_IRQ
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff I_RESET;
	a_gate_reset: assert property ($fell(I_RESET) |-> O_GATE == 14'h08FF)
		else $error("gate reset value");
	a_bit13_low: assert property (O_GATE[13] == 1'b0)
		else $error("bit 13 set");
	a_view_and: assert property (!$past(I_RESET) |-> O_GATED_VIEW == ($past(I_RAW_EVENTS) & O_GATE))
		else $error("gated view");
	a_irq_or: assert property (O_IRQ == |O_GATED_VIEW)
		else $error("request");
	a_rdata_idle: assert property (!$past(I_READ) |-> O_RDATA == 32'h0)
		else $error("read data idle");
	a_read_gate: assert property ($past(I_READ && I_ADDR == 8'h30) |-> O_RDATA == {18'h0, O_GATE})
		else $error("gate read");
	a_read_raw: assert property ($past(I_READ && I_ADDR == 8'h34) |-> O_RDATA[13:0] == $past(I_RAW_EVENTS))
		else $error("raw read");
	a_write_gate: assert property ($past(I_WRITE && I_ADDR == 8'h30) |=> O_GATE == ($past(I_WDATA[13:0], 2) & 14'h1FFF))
		else $error("gate write");
	c_irq: cover property (O_IRQ);
	c_raw: cover property ($past(I_READ && I_ADDR == 8'h34));
	c_wr: cover property (I_WRITE && I_ADDR == 8'h30);
endmodule
bind ims_mask_stage ims_chk i_chk
(
	.I_CORE_CLK(I_CORE_CLK),
	.I_RESET(I_RESET),
	.I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA),
	.I_WRITE(I_WRITE),
	.I_READ(I_READ),
	.O_RDATA(O_RDATA),
	.I_RAW_EVENTS(I_RAW_EVENTS),
	.O_GATED_VIEW(O_GATED_VIEW),
	.O_GATE(O_GATE),
	.O_IRQ(O_IRQ)
);
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the mask stage
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic I_CORE_CLK = 0, I_RESET = 1, I_WRITE = 0, I_READ = 0, rv = 0, ov = 0, O_IRQ;
	logic [7:0] I_ADDR = 0;
	logic [31:0] I_WDATA = 0, O_RDATA, d;
	logic [13:0] I_RAW_EVENTS = 0, O_GATED_VIEW, O_GATE, g, r;
	logic [31:0] q[$];
	logic [28:0] qv[$];
	int n_mismatch = 0, n_checks = 0, i, seed = 32'he615;
	ims_mask_stage i_ims_mask_stage
	(
		.I_CORE_CLK(I_CORE_CLK),
		.I_RESET(I_RESET),
		.I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA),
		.I_WRITE(I_WRITE),
		.I_READ(I_READ),
		.O_RDATA(O_RDATA),
		.I_RAW_EVENTS(I_RAW_EVENTS),
		.O_GATED_VIEW(O_GATED_VIEW),
		.O_GATE(O_GATE),
		.O_IRQ(O_IRQ)
	);
	always #5 I_CORE_CLK = ~I_CORE_CLK;
	task end_of_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// request, gate copy and gated view, all one cycle after the raw flags are taken
	task cmp_ev(input logic [28:0] got, input logic [28:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t event view got %h expected %h", $time, got, exp);
		end
	endtask
	// expected read data queued at the strobe, compared a cycle later
	task op(input logic w, input logic [7:0] a, input logic [31:0] e);
		@(posedge I_CORE_CLK);
		I_WRITE <= w;
		I_READ <= !w;
		I_ADDR <= a;
		I_WDATA <= d;
		I_RAW_EVENTS <= r;
		if (!w)
			q.push_back(e);
		qv.push_back({|(r & g), g, r & g});
	endtask
	always @(posedge I_CORE_CLK)
	begin
		rv <= I_READ;
		ov <= I_READ | I_WRITE;
	end
	always @(negedge I_CORE_CLK)
	begin
		if (rv)
			cmp(O_RDATA, q.pop_front());
		if (ov)
			cmp_ev({O_IRQ, O_GATE, O_GATED_VIEW}, qv.pop_front());
	end
	initial
	begin
		repeat (4) @(posedge I_CORE_CLK);
		I_RESET <= 0;
		d = 0;
		r = 14'h3FFF;
		g = 14'h08FF;
		op(1'b0, 8'h30, 32'h08FF);
		// strobes back to back; each write goes to the gate or, when bit 3 of the loop count is set, to a read-only view
		for (i = 0; i < 200; i++)
		begin
			d = $random(seed);
			r = 14'($random(seed));
			case (i % 5)
				0: op(1'b1, i[3] ? 8'h34 : 8'h30, 32'h0);
				1: op(1'b0, 8'h30, {18'h00000, g});
				2: op(1'b0, 8'h2C, {18'h00000, r & g});
				3: op(1'b0, 8'h34, {18'h00000, r});
				default: op(1'b0, 8'h00, 32'h0);
			endcase
			if (i % 5 == 0 && !i[3])
				g = d[13:0] & 14'h1FFF;
		end
		@(posedge I_CORE_CLK);
		I_READ <= 0;
		I_RESET <= 1;
		@(posedge I_CORE_CLK);
		I_RESET <= 0;
		g = 14'h08FF;
		op(1'b0, 8'h30, 32'h08FF);
		@(posedge I_CORE_CLK);
		I_READ <= 0;
		repeat (2) @(posedge I_CORE_CLK);
		// an expected result left unchecked means a read or event never showed up
		if (q.size() != 0 || qv.size() != 0)
			n_mismatch++;
		end_of_test();
	end
endmodule
`default_nettype wire
